// ### alr_cfg.svh
// register offsets, field positions and reset values for the acl layer-4 entry bank
`ifndef ALR_CFG_SVH
`define ALR_CFG_SVH
`define ALR_ADDR_CTRL 8'h6E
`define ALR_ADDR_OFFSET 8'h6F
`define ALR_ADDR_DATA 8'hA0
`define ALR_TABLE_ACL 3'h2
`define ALR_TBL_HI 7
`define ALR_TBL_LO 5
`define ALR_PORT_HI 3
`define ALR_PORT_LO 0
`define ALR_OFS_MAX_HI 8'h02
`define ALR_OFS_MIN_LO 8'h03
`define ALR_OFS_MODE 8'h04
`define ALR_OFS_PROTO 8'h05
`define ALR_OFS_FMASK 8'h06
`define ALR_RESET_BYTE 8'h00
`define ALR_RESET_MODE 2'h0
`define ALR_RESET_BIT 1'h0
`define ALR_ZERO_BYTE 8'h00
`define ALR_ZERO_BITS5 5'h00
`endif

// ### alr_pkg.sv
// types for the acl layer-4 entry bank
package alr_pkg;
  typedef enum logic [1:0] {
    ALR_CMP_OFF,
    ALR_CMP_EITHER,
    ALR_CMP_INSIDE,
    ALR_CMP_OUTSIDE
  } alr_cmp_mode_t;
  typedef struct packed {
    logic [7:0] max_hi;
    logic [7:0] min_lo;
    logic [1:0] mode;
    logic [7:0] proto;
    logic flag_match_enable;
    logic [7:0] fmask;
  } alr_entry_t;
endpackage

// ### alr_regs.sv
// acl layer-4 entry bytes reached through indirect control, offset and data registers
`timescale 1ns/1ns
`include "alr_cfg.svh"
module alr_regs
  import alr_pkg::*;
#(
  parameter int NUM_PORTS = 5
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic [7:0] sel_ctrl_o,
  output logic [7:0] sel_offset_o,
  output logic [NUM_PORTS-1:0][1:0] port_compare_mode_o,
  output logic [NUM_PORTS-1:0][7:0] ip_protocol_value_o,
  output logic [NUM_PORTS-1:0] flag_match_enable_o,
  output logic [NUM_PORTS-1:0][7:0] tcp_flag_mask_o,
  output logic [NUM_PORTS-1:0][7:0] range_lower_low_o,
  output logic [NUM_PORTS-1:0][7:0] range_upper_high_o
);
  // port field is four bits wide and zero means no port, so more than 15 cannot be reached
  if (NUM_PORTS < 1 || NUM_PORTS > 15) begin : g_bad_ports
    $error("alr_regs: NUM_PORTS must be 1 to 15");
  end

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] offset;
    logic [7:0] rdata;
    alr_entry_t [NUM_PORTS-1:0] ent;
  } alr_state_t;

  alr_state_t s_q;
  alr_state_t s_d;

  logic acl_sel;
  logic [3:0] port_sel;
  logic port_ok;
  logic [7:0] entry_byte;
  int pidx;

  always_comb begin
    acl_sel = (s_q.ctrl[`ALR_TBL_HI:`ALR_TBL_LO] == `ALR_TABLE_ACL);
    port_sel = s_q.ctrl[`ALR_PORT_HI:`ALR_PORT_LO];
    // ports counted from one; zero and out-of-range values reach nothing
    port_ok = acl_sel && (port_sel != 4'h0) && (int'(port_sel) <= NUM_PORTS);
    pidx = port_ok ? int'(port_sel) - 1 : 0;
    entry_byte = `ALR_ZERO_BYTE;
    if (port_ok) begin
      case (s_q.offset)
        `ALR_OFS_MAX_HI: entry_byte = s_q.ent[pidx].max_hi;
        `ALR_OFS_MIN_LO: entry_byte = s_q.ent[pidx].min_lo;
        `ALR_OFS_MODE: entry_byte = {`ALR_ZERO_BITS5, s_q.ent[pidx].mode, s_q.ent[pidx].proto[7]};
        `ALR_OFS_PROTO: entry_byte = {s_q.ent[pidx].proto[6:0], s_q.ent[pidx].flag_match_enable};
        `ALR_OFS_FMASK: entry_byte = s_q.ent[pidx].fmask;
        default: entry_byte = `ALR_ZERO_BYTE;
      endcase
    end
  end

  always_comb begin
    s_d = s_q;
    if (rd_en_i) begin
      if (addr_i == `ALR_ADDR_CTRL) begin
        s_d.rdata = s_q.ctrl;
      end else if (addr_i == `ALR_ADDR_OFFSET) begin
        s_d.rdata = s_q.offset;
      end else if (addr_i == `ALR_ADDR_DATA) begin
        s_d.rdata = entry_byte;
      end else begin
        s_d.rdata = `ALR_ZERO_BYTE;
      end
    end
    if (wr_en_i) begin
      if (addr_i == `ALR_ADDR_CTRL) begin
        s_d.ctrl = wdata_i;
      end else if (addr_i == `ALR_ADDR_OFFSET) begin
        s_d.offset = wdata_i;
      end else if (addr_i == `ALR_ADDR_DATA && port_ok) begin
        // reserved bits 7:3 of byte four are dropped so they read back zero
        case (s_q.offset)
          `ALR_OFS_MAX_HI: s_d.ent[pidx].max_hi = wdata_i;
          `ALR_OFS_MIN_LO: s_d.ent[pidx].min_lo = wdata_i;
          `ALR_OFS_MODE: begin
            s_d.ent[pidx].mode = wdata_i[2:1];
            s_d.ent[pidx].proto[7] = wdata_i[0];
          end
          `ALR_OFS_PROTO: begin
            s_d.ent[pidx].proto[6:0] = wdata_i[7:1];
            s_d.ent[pidx].flag_match_enable = wdata_i[0];
          end
          `ALR_OFS_FMASK: s_d.ent[pidx].fmask = wdata_i;
          default: s_d.ent[pidx].flag_match_enable = s_q.ent[pidx].flag_match_enable;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q.ctrl <= `ALR_RESET_BYTE;
      s_q.offset <= `ALR_RESET_BYTE;
      s_q.rdata <= `ALR_RESET_BYTE;
      for (int i = 0; i < NUM_PORTS; i++) begin
        s_q.ent[i].max_hi <= `ALR_RESET_BYTE;
        s_q.ent[i].min_lo <= `ALR_RESET_BYTE;
        s_q.ent[i].mode <= `ALR_RESET_MODE;
        s_q.ent[i].proto <= `ALR_RESET_BYTE;
        s_q.ent[i].flag_match_enable <= `ALR_RESET_BIT;
        s_q.ent[i].fmask <= `ALR_RESET_BYTE;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // matcher-facing copies come straight from the entry flops
  assign rdata_o = s_q.rdata;
  assign sel_ctrl_o = s_q.ctrl;
  assign sel_offset_o = s_q.offset;
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
    assign port_compare_mode_o[g] = s_q.ent[g].mode;
    assign ip_protocol_value_o[g] = s_q.ent[g].proto;
    assign flag_match_enable_o[g] = s_q.ent[g].flag_match_enable;
    assign tcp_flag_mask_o[g] = s_q.ent[g].fmask;
    assign range_lower_low_o[g] = s_q.ent[g].min_lo;
    assign range_upper_high_o[g] = s_q.ent[g].max_hi;
  end
endmodule

// ### alr_regs_checker.sv
// assertions for the acl layer-4 entry bank
`timescale 1ns/1ns
module alr_regs_checker #(
  parameter int NUM_PORTS = 5
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] sel_ctrl_o,
  input wire logic [7:0] sel_offset_o,
  input wire logic [NUM_PORTS-1:0][1:0] port_compare_mode_o,
  input wire logic [NUM_PORTS-1:0][7:0] ip_protocol_value_o,
  input wire logic [NUM_PORTS-1:0] flag_match_enable_o,
  input wire logic [NUM_PORTS-1:0][7:0] tcp_flag_mask_o,
  input wire logic [NUM_PORTS-1:0][7:0] range_lower_low_o,
  input wire logic [NUM_PORTS-1:0][7:0] range_upper_high_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // port one only; the decode is shared by all ports
  wire wr_p1 = wr_en_i && addr_i == 8'hA0 && sel_ctrl_o == 8'h41;
  wire bad = sel_ctrl_o[7:5] != 3'h2 || sel_ctrl_o[3:0] == 4'h0;
  property p_port; wr_en_i && addr_i == 8'hA0 && bad |=> $stable(tcp_flag_mask_o); endproperty
  property p_rd; rd_en_i && !wr_en_i && addr_i == 8'hA0 && sel_ctrl_o == 8'h41 && sel_offset_o == 8'h06
    |=> rdata_o == $past(tcp_flag_mask_o[0]); endproperty
  property p_lo; wr_p1 && sel_offset_o == 8'h03 |=> range_lower_low_o[0] == $past(wdata_i); endproperty
  property p_mode; wr_p1 && sel_offset_o == 8'h04 |=> port_compare_mode_o[0] == $past(wdata_i[2:1]); endproperty
  property p_pro; wr_p1 && sel_offset_o == 8'h05 |=> ip_protocol_value_o[0][6:0] == $past(wdata_i[7:1]); endproperty
  property p_fme; wr_p1 && sel_offset_o == 8'h05 |=> flag_match_enable_o[0] == $past(wdata_i[0]); endproperty
  property p_hi; wr_p1 && sel_offset_o == 8'h02 |=> range_upper_high_o[0] == $past(wdata_i); endproperty
  property p_msk; wr_p1 && sel_offset_o == 8'h06 |=> tcp_flag_mask_o[0] == $past(wdata_i); endproperty
  a_port: assert property (p_port) else $error("refused write landed");
  a_rd: assert property (p_rd) else $error("read data");
  a_lo: assert property (p_lo) else $error("lower bound");
  a_mode: assert property (p_mode) else $error("mode");
  a_pro: assert property (p_pro) else $error("protocol");
  a_fme: assert property (p_fme) else $error("flag enable");
  a_hi: assert property (p_hi) else $error("upper bound");
  a_msk: assert property (p_msk) else $error("flag mask");
  c_mode: cover property (wr_p1 && sel_offset_o == 8'h04);
  c_rd: cover property (rd_en_i && addr_i == 8'hA0);
  c_bad: cover property (wr_en_i && addr_i == 8'hA0 && bad);
endmodule
bind alr_regs alr_regs_checker #(.NUM_PORTS(NUM_PORTS)) chk (.*);

// ### alr_regs_tb.sv
// self-checking bench for the acl layer-4 entry bank
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module alr_regs_tb;
  logic clk_i = 0, resetn_i = 0, wr_en_i = 0, rd_en_i = 0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, sc, so;
  logic [4:0][7:0] pv, fm, lo, hi;
  logic [4:0][1:0] pc;
  logic [4:0] fe;
  int miscompares = 0, compares = 0;
  always #2 clk_i = ~clk_i;
  alr_regs uut (.clk_i(clk_i), .resetn_i(resetn_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .sel_ctrl_o(sc), .sel_offset_o(so), .port_compare_mode_o(pc),
    .ip_protocol_value_o(pv), .flag_match_enable_o(fe), .tcp_flag_mask_o(fm), .range_lower_low_o(lo),
    .range_upper_high_o(hi));
  // distinct per port and offset, so a wrong port or byte shows
  function automatic logic [7:0] f(int p, int o);
    return 8'(p * 37 + o * 53);
  endfunction
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    wr_en_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_i);
    rd_en_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1 `CHK("rdata", e, rdata_o)
  endtask
  task automatic sel(int p, o);
    wr(8'h6E, 8'(8'h40 + p));
    wr(8'h6F, 8'(o));
  endtask
  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    logic [7:0] m, n;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1 `CHK("reset", 0, {pv, fm, lo, hi, pc, fe})
    for (int p = 1; p <= 5; p++)
      for (int o = 2; o <= 6; o++) begin
        sel(p, o);
        wr(8'hA0, f(p, o));
      end
    for (int p = 1; p <= 5; p++) begin
      m = f(p, 4);
      n = f(p, 5);
      `CHK("hi", f(p, 2), hi[p-1])
      `CHK("lo", f(p, 3), lo[p-1])
      `CHK("mode", m[2:1], pc[p-1])
      `CHK("proto", {m[0], n[7:1]}, pv[p-1])
      `CHK("fme", n[0], fe[p-1])
      `CHK("mask", f(p, 6), fm[p-1])
      sel(p, 4);
      rd(8'hA0, m & 8'h07);
    end
    sel(1, 6);
    rd(8'hA0, f(1, 6));
    // wrong table, then port zero: both must leave the entry alone
    wr(8'h6E, 8'h21);
    wr(8'hA0, 8'h00);
    rd(8'hA0, 8'h00);
    wr(8'h6E, 8'h40);
    wr(8'hA0, 8'h00);
    #1 `CHK("keep", f(1, 6), fm[0])
    rd(8'h33, 8'h00);
    sel(2, 5);
    #1 `CHK("ctrl", 8'h42, sc)
    `CHK("offset", 8'h05, so)
    rd(8'h6E, 8'h42);
    rd(8'h6F, 8'h05);
    wr(8'h6E, 8'h46);
    wr(8'hA0, 8'hFF);
    rd(8'hA0, 8'h00);
    summarize();
  end
endmodule
